// ---- rtl/fra_exec.sv ----
/*
  Execute logic for complement, decrement, decrement-skip and the two
  exclusive-OR operations, plus return-address push on interrupt entry.
  Assumes the fetch unit holds instr/pc stable over a whole instruction
  cycle and the data memory answers reads combinationally in phase 2.
*/
//
// Function
// [RL1] Interrupt entry pushes only the return address
// [RL2] Service software saves accumulator and status itself
// [RL3] Saved status copy lives in bank 0
// [RL4] Complement inverts operand, updates null flag
// [RL5] Target bit 0 to accumulator, 1 to register
// [RL6] Decrement operand, null flag from result
// [RL7] Decrement-skip: no flags, zero result skips next
// [RL8] Literal XOR into accumulator, updates null flag
// [RL9] Register XOR to target, updates null flag
// [RL10] Decode, read, compute, write across four phases
// [RL11] Target bit 7, address bits 6 to 0
`include "fra_defs.svh"
module fra_exec
  import fra_pkg::*;
#(
  parameter int ADDR_W = 7,
  parameter int PC_W = 13
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [13:0] instr,
  input wire logic [PC_W-1:0] pc,
  input wire logic irq_take,
  input wire logic [7:0] mem_rdata,
  input wire logic null_flag_in,
  output logic [ADDR_W-1:0] mem_addr_q,
  output logic [7:0] mem_wdata_q,
  output logic mem_we_q,
  output logic [7:0] acc_q,
  output logic result_null_flag_q,
  output logic null_we_q,
  output logic skip_q,
  output logic [PC_W-1:0] stack_push_data_q,
  output logic stack_push_q,
  output logic [PC_W-1:0] irq_vector_q,
  output logic irq_jump_q,
  output fra_phase_t phase_q
);
  // ============================================================
  // Phase sequencing
  fra_phase_t ph;
  logic cyc_end;
  fra_phase_gen u_phase (
    .clk(clk),
    .rst(rst),
    .phase_q(ph),
    .cycle_end(cyc_end)
  );

  // Shared arithmetic
  function automatic logic is_zero(input logic [7:0] v);
    return v == 8'h00;
  endfunction : is_zero

  // ============================================================
  // Decode wires
  wire [1:0] cls = instr[`FRA_CLASS_HI:`FRA_CLASS_LO];
  wire [3:0] opc = instr[`FRA_OPC_HI:`FRA_OPC_LO];
  wire dest_w = instr[`FRA_DEST_BIT]; // RL11
  wire [ADDR_W-1:0] addr_w = instr[ADDR_W-1:0]; // RL11
  wire [7:0] lit_w = instr[7:0];
  fra_op_t dec_op;
  assign dec_op = (cls == `FRA_CLASS_REG && opc == `FRA_OPC_COMP) ? FRA_OP_COMP :
                  (cls == `FRA_CLASS_REG && opc == `FRA_OPC_DEC) ? FRA_OP_DEC :
                  (cls == `FRA_CLASS_REG && opc == `FRA_OPC_DECSKIP) ? FRA_OP_DECSKIP :
                  (cls == `FRA_CLASS_REG && opc == `FRA_OPC_XORREG) ? FRA_OP_XORREG :
                  (cls == `FRA_CLASS_LIT && opc == `FRA_OPC_XORLIT) ? FRA_OP_XORLIT :
                  FRA_OP_NONE;

  // ============================================================
  // Latched state across the cycle
  fra_op_t op_q;
  logic dest_q;
  logic nop_q; // This cycle is a skipped slot
  logic [7:0] opnd_q;
  logic [7:0] res_q;
  logic [7:0] acc_d;
  logic [7:0] res_d;

  // Compute from latched operand
  always_comb begin
    res_d = opnd_q;
    unique case (op_q)
      FRA_OP_COMP: res_d = ~opnd_q; // RL4
      FRA_OP_DEC, FRA_OP_DECSKIP: res_d = opnd_q - 8'h01; // RL6 RL7
      FRA_OP_XORREG, FRA_OP_XORLIT: res_d = acc_q ^ opnd_q; // RL8 RL9
      FRA_OP_NONE: res_d = opnd_q;
    endcase
  end

  wire wr_phase = (ph == FRA_PH4) && !nop_q && (op_q != FRA_OP_NONE);
  wire to_acc = (op_q == FRA_OP_XORLIT) || !dest_q; // RL5
  wire flag_op = (op_q == FRA_OP_COMP) || (op_q == FRA_OP_DEC)
              || (op_q == FRA_OP_XORREG) || (op_q == FRA_OP_XORLIT);
  assign acc_d = (wr_phase && to_acc) ? res_q : acc_q; // RL5

  // ============================================================
  // Phase 1: decode; phase 2: read; phase 3: compute
  always_ff @(posedge clk) begin
    if (rst) begin
      op_q <= FRA_OP_NONE;
      dest_q <= 1'b0;
      opnd_q <= 8'h00;
      res_q <= 8'h00;
      mem_addr_q <= '0;
    end else begin
      if (ph == FRA_PH1) begin
        op_q <= nop_q ? FRA_OP_NONE : dec_op; // RL10
        dest_q <= dest_w;
        mem_addr_q <= addr_w;
      end
      if (ph == FRA_PH2) begin
        opnd_q <= (op_q == FRA_OP_XORLIT) ? lit_w : mem_rdata; // RL10
      end
      if (ph == FRA_PH3) begin
        res_q <= res_d; // RL10
      end
    end
  end

  // Phase 4: write the destination and flags
  always_ff @(posedge clk) begin
    if (rst) begin
      acc_q <= `FRA_ACC_RESET;
      mem_we_q <= 1'b0;
      mem_wdata_q <= 8'h00;
      null_we_q <= 1'b0;
      result_null_flag_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      mem_we_q <= wr_phase && !to_acc; // RL5 RL10
      mem_wdata_q <= res_q;
      null_we_q <= wr_phase && flag_op; // RL7
      result_null_flag_q <= (wr_phase && flag_op) ? is_zero(res_q) : null_flag_in; // RL6
    end
  end

  // Skip: the next instruction slot becomes a no-operation
  always_ff @(posedge clk) begin
    if (rst) begin
      nop_q <= 1'b0;
      skip_q <= 1'b0;
    end else begin
      skip_q <= wr_phase && (op_q == FRA_OP_DECSKIP) && is_zero(res_q); // RL7
      if (cyc_end) begin
        nop_q <= !nop_q && (op_q == FRA_OP_DECSKIP) && is_zero(res_q); // RL7
      end
    end
  end

  // ============================================================
  // Interrupt entry: only the return address is pushed; the
  // accumulator and status stay for software to save.
  always_ff @(posedge clk) begin
    if (rst) begin
      stack_push_q <= 1'b0;
      stack_push_data_q <= '0;
      irq_jump_q <= 1'b0;
      irq_vector_q <= '0;
    end else begin
      stack_push_q <= irq_take && cyc_end; // RL1
      irq_jump_q <= irq_take && cyc_end;
      stack_push_data_q <= pc; // RL1
      irq_vector_q <= PC_W'(`FRA_IRQ_VECTOR);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) phase_q <= FRA_PH1;
    else phase_q <= ph;
  end

  // ============================================================
  // Checks
  write_in_ph4_a: assert property (@(posedge clk) disable iff (rst)
    mem_we_q |-> $past(ph == FRA_PH4)) // RL10
    else $error("register write outside phase 4");
  skip_no_flag_a: assert property (@(posedge clk) disable iff (rst)
    (ph == FRA_PH4 && op_q == FRA_OP_DECSKIP) |=> !null_we_q) // RL7
    else $error("decrement-skip touched flag");
  skip_nop_a: assert property (@(posedge clk) disable iff (rst)
    skip_q |-> nop_q[*4] ##1 (!mem_we_q && !null_we_q)) // RL7
    else $error("skipped slot not a no-operation");
  comp_value_a: assert property (@(posedge clk) disable iff (rst)
    (ph == FRA_PH3 && op_q == FRA_OP_COMP) |=> res_q == ~$past(opnd_q)) // RL4
    else $error("complement wrong");
  dec_flag_a: assert property (@(posedge clk) disable iff (rst)
    (wr_phase && op_q == FRA_OP_DEC) |=> null_we_q && result_null_flag_q == (mem_wdata_q == 8'h00)) // RL6
    else $error("decrement flag wrong");
  xorlit_acc_a: assert property (@(posedge clk) disable iff (rst)
    (wr_phase && op_q == FRA_OP_XORLIT) |=> acc_q == $past(res_q) && !mem_we_q) // RL8
    else $error("literal xor not to accumulator");
  dest_reg_a: assert property (@(posedge clk) disable iff (rst)
    (wr_phase && dest_q && op_q == FRA_OP_XORREG) |=> mem_we_q && $stable(acc_q)) // RL5 RL9
    else $error("register destination ignored");
  irq_push_a: assert property (@(posedge clk) disable iff (rst)
    (irq_take && cyc_end) |=> stack_push_q && stack_push_data_q == $past(pc)
      && $stable(acc_q)) // RL1
    else $error("interrupt entry wrong");
endmodule : fra_exec

// ---- rtl/fra_defs.svh ----
/*
  Constants for the byte-operation execute block: opcode fields, phase
  timing and interrupt vector. Assumes inclusion by bare name.
*/
`ifndef FRA_DEFS_SVH
`define FRA_DEFS_SVH

// ============================================================
// Instruction fields
`define FRA_CLASS_HI 13
`define FRA_CLASS_LO 12
`define FRA_OPC_HI 11
`define FRA_OPC_LO 8
`define FRA_DEST_BIT 7
`define FRA_ADDR_HI 6
`define FRA_CLASS_REG 2'h0
`define FRA_CLASS_LIT 2'h3
`define FRA_OPC_COMP 4'h9
`define FRA_OPC_DEC 4'h3
`define FRA_OPC_DECSKIP 4'hb
`define FRA_OPC_XORREG 4'h6
`define FRA_OPC_XORLIT 4'ha

// ============================================================
// Timing and reset values
`define FRA_PHASES 4
`define FRA_CLK_NS 10
`define FRA_IRQ_VECTOR 13'h0004
`define FRA_ACC_RESET 8'h00

`endif

// ---- rtl/fra_pkg.sv ----
/*
  Types for the byte-operation execute block.
  Assumes fra_defs.svh is on the include path.
*/
package fra_pkg;
  // One-hot phase of the instruction cycle
  typedef enum logic [3:0] {
    FRA_PH1 = 4'h1,
    FRA_PH2 = 4'h2,
    FRA_PH3 = 4'h4,
    FRA_PH4 = 4'h8
  } fra_phase_t;

  // Decoded operation kind
  typedef enum logic [2:0] {
    FRA_OP_NONE = 3'h0,
    FRA_OP_COMP = 3'h1,
    FRA_OP_DEC = 3'h2,
    FRA_OP_DECSKIP = 3'h3,
    FRA_OP_XORREG = 3'h4,
    FRA_OP_XORLIT = 3'h5
  } fra_op_t;
endpackage : fra_pkg

// ---- rtl/fra_phase_gen.sv ----
/*
  Four-phase sequencer: divides clk into the phases of one instruction
  cycle. Assumes a synchronous active-high reset.
*/
`include "fra_defs.svh"
module fra_phase_gen
  import fra_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  output fra_phase_t phase_q,
  output logic cycle_end
);
  // ============================================================
  // Phase rotation
  always_ff @(posedge clk) begin
    if (rst) begin
      phase_q <= FRA_PH1;
    end else begin
      unique case (phase_q)
        FRA_PH1: phase_q <= FRA_PH2;
        FRA_PH2: phase_q <= FRA_PH3;
        FRA_PH3: phase_q <= FRA_PH4;
        FRA_PH4: phase_q <= FRA_PH1;
        default: phase_q <= FRA_PH1; // Recover from illegal code
      endcase
    end
  end

  // Enable pulse in the last phase
  assign cycle_end = (phase_q == FRA_PH4);

  phase_onehot_a: assert property (@(posedge clk) disable iff (rst) $onehot(phase_q))
    else $error("phase not one-hot");
endmodule : fra_phase_gen

// ---- verif/test_file_register_alu_ops.sv ----
/*
  Self-checking bench for the byte-operation execute block.
  Assumes fra_pkg is compiled first and fra_defs.svh is on the include path.
*/
`include "fra_defs.svh"
module test_file_register_alu_ops
  import fra_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // ============================================================
  // Signals
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [13:0] instr = 14'h0000;
  logic [12:0] pc = 13'h0abc;
  logic irq_take = 1'b0;
  logic null_in = 1'b0;
  logic [7:0] mem [128];
  logic [7:0] mem_rdata, mem_wdata_q, acc_q, wd, acc;
  logic [6:0] mem_addr_q, wa;
  logic [12:0] stack_push_data_q, irq_vector_q, pd, vd;
  logic mem_we_q, result_null_flag_q, null_we_q, skip_q, stack_push_q, irq_jump_q;
  logic saw_we, saw_nw, saw_sk, saw_push, saw_jmp, nf;
  fra_phase_t phase_q;
  int failures = 0;
  int tests_run = 0;
  int cyc = 0;
  int start = 0;
  int we_at = 0;

  always #5 clk = ~clk;
  // Register file answers at once, as the execute block expects in phase 2
  assign mem_rdata = mem[mem_addr_q];

  fra_exec uut (
    .clk(clk), .rst(rst), .instr(instr), .pc(pc), .irq_take(irq_take),
    .mem_rdata(mem_rdata), .null_flag_in(null_in), .mem_addr_q(mem_addr_q),
    .mem_wdata_q(mem_wdata_q), .mem_we_q(mem_we_q), .acc_q(acc_q),
    .result_null_flag_q(result_null_flag_q), .null_we_q(null_we_q), .skip_q(skip_q),
    .stack_push_data_q(stack_push_data_q), .stack_push_q(stack_push_q),
    .irq_vector_q(irq_vector_q), .irq_jump_q(irq_jump_q), .phase_q(phase_q));

  // Latch one-cycle pulses 2 ns after each clock edge so they are never missed
  always @(posedge clk) begin
    #2;
    cyc = cyc + 1;
    if (mem_we_q === 1'b1) begin
      saw_we = 1'b1;
      wd = mem_wdata_q;
      wa = mem_addr_q;
      we_at = cyc;
      mem[mem_addr_q] = mem_wdata_q;
    end
    if (null_we_q === 1'b1) begin
      saw_nw = 1'b1;
      nf = result_null_flag_q;
    end
    if (skip_q === 1'b1) saw_sk = 1'b1;
    if (stack_push_q === 1'b1) begin
      saw_push = 1'b1;
      pd = stack_push_data_q;
    end
    if (irq_jump_q === 1'b1) begin
      saw_jmp = 1'b1;
      vd = irq_vector_q;
    end
  end

  // ============================================================
  // Helpers
  task automatic check(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      failures++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask : check

  task automatic clr();
    saw_we = 1'b0;
    saw_nw = 1'b0;
    saw_sk = 1'b0;
    saw_push = 1'b0;
    saw_jmp = 1'b0;
    start = cyc;
  endtask : clr

  // One instruction cycle of four clocks; word stays put the whole cycle
  task automatic slot(input logic [13:0] word);
    instr = word;
    repeat (4) @(posedge clk);
    #1;
  endtask : slot

  task automatic run(input logic [13:0] word);
    clr();
    slot(word);
    slot(14'h0000);
  endtask : run

  // Register operand: result to register or accumulator, zero flag optional
  task automatic op_chk(input logic [3:0] opc, input logic d, input logic [6:0] a,
                        input logic [7:0] val, input logic [7:0] exp, input logic fl);
    mem[a] = val;
    run({`FRA_CLASS_REG, opc, d, a});
    if (d) begin
      check(saw_we === 1'b1 && wa === a && wd === exp && acc_q === acc, "register result");
      check(we_at - start >= 4 && we_at - start <= 5, "write timing");
    end else begin
      check(saw_we === 1'b0 && acc_q === exp, "accumulator result");
      acc = exp;
    end
    check(saw_nw === fl && (!fl || nf === (exp == 8'h00)), "zero flag");
  endtask : op_chk

  // ============================================================
  // Scenarios
  task automatic t_xor_lit();
    run({`FRA_CLASS_LIT, `FRA_OPC_XORLIT, 8'ha5});
    check(acc_q === 8'ha5 && saw_nw === 1'b1 && nf === 1'b0 && !saw_we, "literal xor");
    run({`FRA_CLASS_LIT, `FRA_OPC_XORLIT, 8'ha5});
    check(acc_q === 8'h00 && saw_nw === 1'b1 && nf === 1'b1, "literal xor zero");
    acc = 8'h00;
  endtask : t_xor_lit

  task automatic t_comp();
    op_chk(`FRA_OPC_COMP, 1'b1, 7'h7f, 8'h0f, 8'hf0, 1'b1);
    op_chk(`FRA_OPC_COMP, 1'b0, 7'h05, 8'hff, 8'h00, 1'b1);
  endtask : t_comp

  task automatic t_dec();
    op_chk(`FRA_OPC_DEC, 1'b1, 7'h10, 8'h01, 8'h00, 1'b1);
    op_chk(`FRA_OPC_DEC, 1'b0, 7'h00, 8'h00, 8'hff, 1'b1);
  endtask : t_dec

  task automatic t_xor_reg();
    op_chk(`FRA_OPC_XORREG, 1'b1, 7'h20, 8'h0f, acc ^ 8'h0f, 1'b1);
    op_chk(`FRA_OPC_XORREG, 1'b0, 7'h21, 8'hff, acc ^ 8'hff, 1'b1);
  endtask : t_xor_reg

  // Skip must swallow the very next word, here a literal xor
  task automatic t_decskip();
    op_chk(`FRA_OPC_DECSKIP, 1'b1, 7'h12, 8'h02, 8'h01, 1'b0);
    check(saw_sk === 1'b0, "no skip on nonzero");
    clr();
    slot({`FRA_CLASS_REG, `FRA_OPC_DECSKIP, 1'b1, 7'h12});
    slot({`FRA_CLASS_LIT, `FRA_OPC_XORLIT, 8'h3c});
    slot(14'h0000);
    check(saw_sk === 1'b1 && mem[18] === 8'h00 && !saw_nw, "skip on zero");
    check(acc_q === acc, "skipped word ignored");
  endtask : t_decskip

  task automatic t_irq();
    clr();
    irq_take = 1'b1;
    slot(14'h0000);
    irq_take = 1'b0;
    slot(14'h0000);
    check(saw_push === 1'b1 && pd === pc, "return address push");
    check(saw_jmp === 1'b1 && vd === `FRA_IRQ_VECTOR, "vector jump");
    check(acc_q === acc && !saw_we && !saw_nw, "nothing else saved");
  endtask : t_irq

  // Service software keeps its own copies; status copy at a bank-0 address
  task automatic t_isr_save();
    run({`FRA_CLASS_LIT, `FRA_OPC_XORLIT, 8'h5a});
    acc = 8'h5a;
    null_in = 1'b1;
    irq_take = 1'b1;
    slot(14'h0000);
    irq_take = 1'b0;
    check(acc_q === acc && result_null_flag_q === 1'b1, "entry kept context");
    mem[7'h71] = {7'h00, result_null_flag_q};
    op_chk(`FRA_OPC_XORREG, 1'b1, 7'h70, 8'h00, acc, 1'b1);
    null_in = 1'b0;
    run({`FRA_CLASS_LIT, `FRA_OPC_XORLIT, 8'hff});
    check(acc_q === 8'ha5 && mem[7'h70] === 8'h5a, "saved copy intact");
    acc = 8'ha5;
    op_chk(`FRA_OPC_XORREG, 1'b0, 7'h72, 8'hff, acc ^ 8'hff, 1'b1);
    check(acc_q === mem[7'h70], "accumulator restored");
    null_in = mem[7'h71][0];
    slot(14'h0000);
    check(result_null_flag_q === 1'b1, "status restored");
  endtask : t_isr_save

  // ============================================================
  // Verdict and run control
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test

  // Whole run is about 35 instruction cycles; this is about fourteen times that
  initial begin
    #20000;
    failures++;
    finish_test();
  end

  initial begin
    for (int i = 0; i < 128; i++) mem[i] = 8'h00;
    acc = `FRA_ACC_RESET;
    repeat (3) @(posedge clk);
    #1;
    rst = 1'b0;
    // First edge after release decodes; wait a whole cycle so slots start in phase 1
    repeat (4) @(posedge clk);
    #1;
    check(acc_q === `FRA_ACC_RESET && mem_we_q === 1'b0 && phase_q === FRA_PH4, "reset state");
    t_xor_lit();
    t_comp();
    t_dec();
    t_xor_reg();
    t_decskip();
    t_irq();
    t_isr_save();
    finish_test();
  end
endmodule : test_file_register_alu_ops
